// file: hw/drc_coast_timer.sv
// seconds timer that orders a coast after start release
`timescale 1ns/1ns
module drc_coast_timer
    import drc_pkg::*;
#(
    parameter int SEC_CYC = SEC_CYCLES
)(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    drc_core_if.timer        bus
);
    logic [25:0] div_count;
    logic        sec_tick;
    logic [6:0]  sec_count;
    wire         reached = (sec_count >= bus.timer_limit);
    wire         div_wrap = (div_count == 26'(SEC_CYC - 1));

    always_ff @(posedge clk_in) begin
        if (rst_in || !bus.timer_run) begin
            div_count <= 26'h0000000;
            sec_tick  <= 1'b0;
        end else begin
            div_count <= div_wrap ? 26'h0000000 : div_count + 26'h0000001;
            sec_tick  <= div_wrap;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || !bus.timer_run) begin
            sec_count      <= 7'h00;
            bus.timer_done <= 1'b0;
        end else begin
            if (sec_tick && !reached)
                sec_count <= sec_count + 7'h01;
            bus.timer_done <= reached;
        end
    end

    timer_early_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $rose(bus.timer_done) |-> $past(sec_count) >= bus.timer_limit)
        else $error("coast ordered before the delay elapsed");
endmodule

// file: hw/drc_core_if.sv
// signals between the decoder core, its synchroniser and its coast timer
`timescale 1ns/1ns
interface drc_core_if;
    logic [4:0] term;
    logic       timer_run;
    logic [6:0] timer_limit;
    logic       timer_done;
    modport syncer (output term);
    modport timer  (input timer_run, input timer_limit, output timer_done);
    modport core   (input term, input timer_done,
                    output timer_run, output timer_limit);
endinterface

// file: hw/drc_pkg.sv
// constants shared by the run command decoder modules
package drc_pkg;
    localparam int          NUM_TERMS         = 5;
    localparam int          FUNC_W            = 7;
    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 32;
    localparam int          SYNC_STAGES       = 2;
    // register byte addresses
    localparam logic [7:0]  ADDR_SHUTOFF      = 8'h00;
    localparam logic [7:0]  ADDR_STOP_METHOD  = 8'h04;
    localparam logic [7:0]  ADDR_FUNC_LO      = 8'h08;
    localparam logic [7:0]  ADDR_FUNC_HI      = 8'h0C;
    localparam logic [7:0]  ADDR_COMM         = 8'h10;
    localparam logic [7:0]  ADDR_STATUS       = 8'h14;
    // terminal function codes
    localparam logic [6:0]  FN_SECOND_SET     = 7'h03;
    localparam logic [6:0]  FN_INCHING        = 7'h05;
    localparam logic [6:0]  FN_SHUTOFF        = 7'h18;
    localparam logic [6:0]  FN_STOP_HOLD      = 7'h19;
    localparam logic [6:0]  FN_FORWARD        = 7'h3C;
    localparam logic [6:0]  FN_REVERSE        = 7'h3D;
    localparam logic [6:0]  FN_NONE           = 7'h7F;
    // values after reset
    localparam logic [6:0]  RST_FUNC_T0       = FN_FORWARD;
    localparam logic [6:0]  RST_FUNC_T1       = FN_REVERSE;
    localparam logic [6:0]  RST_FUNC_T2       = 7'h00;
    localparam logic [6:0]  RST_FUNC_T3       = 7'h01;
    localparam logic [6:0]  RST_FUNC_T4       = 7'h02;
    localparam logic [2:0]  RST_SHUTOFF       = 3'h0;
    localparam logic [13:0] RST_STOP_METHOD   = 14'h270F;
    // shutoff contact logic settings
    localparam logic [2:0]  SHUT_NO           = 3'h0;
    localparam logic [2:0]  SHUT_NC           = 3'h2;
    localparam logic [2:0]  SHUT_NC_COMM_NO   = 3'h4;
    // stop method settings
    localparam logic [13:0] STOP_TIMED_MAX    = 14'h0064;
    localparam logic [13:0] STOP_LONG_MIN     = 14'h03E8;
    localparam logic [13:0] STOP_LONG_MAX     = 14'h044C;
    localparam logic [13:0] STOP_THREE_RAMP   = 14'h22B8;
    // timing
    localparam int          CLK_PERIOD_NS     = 20;
    localparam int          SEC_NS            = 1_000_000_000;
    localparam int          SEC_CYCLES        = SEC_NS / CLK_PERIOD_NS;
    localparam int          SHUTOFF_RESP_NS   = 2_000_000;
    localparam int          CMD_RESP_NS       = 20_000_000;
    localparam int          SHUTOFF_RESP_CYC  =
        SHUTOFF_RESP_NS / CLK_PERIOD_NS;
    localparam int          CMD_RESP_CYC      = CMD_RESP_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        ST_STOP, ST_RUN, ST_DECEL, ST_COAST
    } drc_state_e;
endpackage

// file: hw/drc_run_cmd.sv
// run command decoder: shutoff, second set, start and stop method
`timescale 1ns/1ns
// What this block does
// - shutoff function code 24 cuts output
// - no start while shutoff asserted
// - shutoff coasts; plain release ramps down
// - logic 0 normally open, 2 normally closed
// - logic 4: terminal closed, communication open
// - only table combinations enable operation
// - shutoff acts for every command source
// - function code 3 selects second set
// - second set values switch together
// - 9999: forward/reverse inputs, both equal stops
// - 1000-1100, 8888: start plus direction input
// - 0-100 s: coast after that delay
// - 1000-1100: coast after setting minus 1000
// - code 25 stop input enables self-holding
// - start pulse on-off latches that direction
// - stop input release clears hold, ramps
// - inching select ignores stop, no holding
// - shutoff keeps a latched held start
// - shutoff within 2 ms, others 20 ms
// - same function on several terminals ORed
module drc_run_cmd
    import drc_pkg::*;
#(
    parameter int SEC_CYC = SEC_CYCLES
)(
    input  wire logic        REF_CLK_IN,
    input  wire logic        RESET_IN,
    input  wire logic [4:0]  TERM_IN,
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [31:0] WR_DATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [31:0] RD_DATA_OUT,
    output logic             GATE_ENABLE_OUT,
    output logic             RUN_OUT,
    output logic             DECEL_OUT,
    output logic             COAST_OUT,
    output logic             REVERSE_OUT,
    output logic             SECOND_SET_OUT
);
    drc_core_if core_bus ();

    drc_sync u_sync (
        .clk_in  (REF_CLK_IN),
        .rst_in  (RESET_IN),
        .term_in (TERM_IN),
        .bus     (core_bus.syncer)
    );

    drc_coast_timer #(.SEC_CYC(SEC_CYC)) u_timer (
        .clk_in (REF_CLK_IN),
        .rst_in (RESET_IN),
        .bus    (core_bus.timer)
    );

    // OR of every terminal that carries the given function code
    function automatic logic fn_on(input logic [34:0] codes,
                                   input logic [4:0]  bits,
                                   input logic [6:0]  code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_TERMS; i++)
            hit = hit | (bits[i] && codes[i*FUNC_W +: FUNC_W] == code);
        return hit;
    endfunction

    // registers
    logic [2:0]  shutoff_logic_select;
    logic [13:0] stop_method_select;
    logic [34:0] func_codes;
    logic        comm_shutoff;
    drc_state_e  state;
    logic        held_run;
    logic        held_rev;
    logic        fwd_prev;
    logic        rev_prev;

    // terminal decoding
    wire [4:0] term          = core_bus.term;
    wire output_shutoff_in   = fn_on(func_codes, term, FN_SHUTOFF);
    wire second_set_select   = fn_on(func_codes, term, FN_SECOND_SET);
    wire forward_start_in    = fn_on(func_codes, term, FN_FORWARD);
    wire reverse_start_in    = fn_on(func_codes, term, FN_REVERSE);
    wire stop_hold_in        = fn_on(func_codes, term, FN_STOP_HOLD);
    wire inching_in          = fn_on(func_codes, term, FN_INCHING);

    // shutoff contact logic, independent of the command source
    wire en_no   = (shutoff_logic_select == SHUT_NO) &&
                   !output_shutoff_in && !comm_shutoff;
    wire en_nc   = (shutoff_logic_select == SHUT_NC) &&
                   output_shutoff_in && comm_shutoff;
    wire en_mix  = (shutoff_logic_select == SHUT_NC_COMM_NO) &&
                   output_shutoff_in && !comm_shutoff;
    wire op_enable = en_no || en_nc || en_mix;

    // stop method decoding
    wire timed_short = (stop_method_select <= STOP_TIMED_MAX);
    wire timed_long  = (stop_method_select >= STOP_LONG_MIN) &&
                       (stop_method_select <= STOP_LONG_MAX);
    wire timed       = timed_short || timed_long;
    wire three_wire  = timed_long ||
                       (stop_method_select == STOP_THREE_RAMP);
    wire [13:0] long_delay = stop_method_select - STOP_LONG_MIN;
    wire [6:0]  coast_limit = timed_long ? long_delay[6:0]
                                         : stop_method_select[6:0];

    // self-holding
    wire hold_mode = stop_hold_in && !inching_in;
    wire fwd_fall  = fwd_prev && !forward_start_in;
    wire rev_fall  = rev_prev && !reverse_start_in;

    // start and direction request
    wire wire_run  = three_wire ? forward_start_in
                               : (forward_start_in ^ reverse_start_in);
    wire run_req   = hold_mode ? held_run : wire_run;
    wire rev_req   = hold_mode ? held_rev : reverse_start_in;

    // run state sequencing
    drc_state_e next_state;
    always_comb begin
        next_state = state;
        if (!op_enable) begin
            next_state = ST_COAST;
        end else begin
            unique case (state)
                ST_STOP, ST_COAST: begin
                    if (run_req)
                        next_state = ST_RUN;
                end
                ST_RUN: begin
                    if (!run_req)
                        next_state = ST_DECEL;
                end
                ST_DECEL: begin
                    if (run_req)
                        next_state = ST_RUN;
                    else if (timed && core_bus.timer_done)
                        next_state = ST_COAST;
                end
            endcase
        end
    end

    wire next_rev = (next_state == ST_RUN) ? rev_req : REVERSE_OUT;

    assign core_bus.timer_run   = (state == ST_DECEL) && timed;
    assign core_bus.timer_limit = coast_limit;

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            state           <= ST_STOP;
            GATE_ENABLE_OUT <= 1'b0;
            RUN_OUT         <= 1'b0;
            DECEL_OUT       <= 1'b0;
            COAST_OUT       <= 1'b0;
            REVERSE_OUT     <= 1'b0;
        end else begin
            state           <= next_state;
            GATE_ENABLE_OUT <= (next_state == ST_RUN) ||
                               (next_state == ST_DECEL);
            RUN_OUT         <= (next_state == ST_RUN);
            DECEL_OUT       <= (next_state == ST_DECEL);
            COAST_OUT       <= (next_state == ST_COAST);
            REVERSE_OUT     <= next_rev;
        end
    end

    // second set select drives all second-set parameters at once
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN)
            SECOND_SET_OUT <= 1'b0;
        else
            SECOND_SET_OUT <= second_set_select;
    end

    // self-holding latch; shutoff does not touch it
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            held_run <= 1'b0;
            held_rev <= 1'b0;
            fwd_prev <= 1'b0;
            rev_prev <= 1'b0;
        end else begin
            fwd_prev <= forward_start_in;
            rev_prev <= reverse_start_in;
            if (!hold_mode) begin
                held_run <= 1'b0;
                held_rev <= 1'b0;
            end else if (fwd_fall) begin
                held_run <= 1'b1;
                held_rev <= 1'b0;
            end else if (rev_fall) begin
                held_run <= 1'b1;
                held_rev <= 1'b1;
            end
        end
    end

    // register bus
    wire wr_shutoff = WR_IN && (ADDR_IN == ADDR_SHUTOFF);
    wire wr_method  = WR_IN && (ADDR_IN == ADDR_STOP_METHOD);
    wire wr_lo      = WR_IN && (ADDR_IN == ADDR_FUNC_LO);
    wire wr_hi      = WR_IN && (ADDR_IN == ADDR_FUNC_HI);
    wire wr_comm    = WR_IN && (ADDR_IN == ADDR_COMM);
    wire [31:0] status_word = {16'h0000, 3'h0, term,
                               held_rev, held_run, op_enable,
                               SECOND_SET_OUT, REVERSE_OUT,
                               1'b0, state};
    wire [31:0] func_lo_word = {1'b0, func_codes[27:21],
                                1'b0, func_codes[20:14],
                                1'b0, func_codes[13:7],
                                1'b0, func_codes[6:0]};
    logic [31:0] next_rd_data;
    always_comb begin
        next_rd_data = 32'h00000000;
        unique case (ADDR_IN)
            ADDR_SHUTOFF:     next_rd_data = {29'h0, shutoff_logic_select};
            ADDR_STOP_METHOD: next_rd_data = {18'h0, stop_method_select};
            ADDR_FUNC_LO:     next_rd_data = func_lo_word;
            ADDR_FUNC_HI:     next_rd_data = {25'h0, func_codes[34:28]};
            ADDR_COMM:        next_rd_data = {31'h0, comm_shutoff};
            ADDR_STATUS:      next_rd_data = status_word;
            default:          next_rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN)
            RD_DATA_OUT <= 32'h00000000;
        else if (RD_IN)
            RD_DATA_OUT <= next_rd_data;
        else
            RD_DATA_OUT <= 32'h00000000;
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            shutoff_logic_select <= RST_SHUTOFF;
            stop_method_select   <= RST_STOP_METHOD;
            func_codes           <= {RST_FUNC_T4, RST_FUNC_T3, RST_FUNC_T2,
                                     RST_FUNC_T1, RST_FUNC_T0};
            comm_shutoff         <= 1'b0;
        end else begin
            if (wr_shutoff)
                shutoff_logic_select <= WR_DATA_IN[2:0];
            if (wr_method)
                stop_method_select <= WR_DATA_IN[13:0];
            if (wr_lo)
                func_codes[27:0] <= {WR_DATA_IN[30:24], WR_DATA_IN[22:16],
                                     WR_DATA_IN[14:8], WR_DATA_IN[6:0]};
            if (wr_hi)
                func_codes[34:28] <= WR_DATA_IN[6:0];
            if (wr_comm)
                comm_shutoff <= WR_DATA_IN[0];
        end
    end

    // checks
    shutoff_cut_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        !op_enable |=> COAST_OUT && !GATE_ENABLE_OUT)
        else $error("output not cut while shut off");

    start_refused_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        !op_enable && run_req |=> !RUN_OUT)
        else $error("start taken while shut off");

    release_ramp_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        state == ST_RUN && !run_req && op_enable |=> DECEL_OUT && !COAST_OUT)
        else $error("start release did not ramp down");

    nc_logic_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        shutoff_logic_select == SHUT_NC && !output_shutoff_in |-> !op_enable)
        else $error("open contact failed to shut off");

    mixed_logic_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        shutoff_logic_select == SHUT_NC_COMM_NO && comm_shutoff
        |-> !op_enable)
        else $error("communication shutoff ignored");

    second_set_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        ##1 SECOND_SET_OUT == $past(second_set_select))
        else $error("second set select not followed");

    two_wire_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        !three_wire && !hold_mode && forward_start_in && reverse_start_in
        |-> !run_req)
        else $error("both start inputs did not stop");

    three_dir_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        three_wire && !hold_mode && op_enable && forward_start_in &&
        reverse_start_in |=> RUN_OUT && REVERSE_OUT)
        else $error("start with direction did not reverse");

    hold_latch_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        hold_mode && fwd_fall |=> held_run && !held_rev)
        else $error("forward pulse not latched");

    stop_clear_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        !hold_mode |=> !held_run)
        else $error("held start kept after stop release");

    hold_kept_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        held_run && hold_mode |=> held_run)
        else $error("held start lost while stop asserted");

    mix_enable_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        shutoff_logic_select == SHUT_NC_COMM_NO && output_shutoff_in &&
        !comm_shutoff && run_req |=> RUN_OUT)
        else $error("closed terminal contact did not enable");

    fwd_rev_run_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        !three_wire && !hold_mode && op_enable &&
        (forward_start_in ^ reverse_start_in)
        |=> RUN_OUT && REVERSE_OUT == $past(reverse_start_in))
        else $error("single start input did not run");

    timed_coast_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        state == ST_DECEL && timed && core_bus.timer_done && !run_req &&
        op_enable |=> COAST_OUT)
        else $error("coast not ordered after the delay");

    hold_start_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        hold_mode && !held_run |=> !RUN_OUT)
        else $error("start input ran without a held pulse");

    inching_hold_a: assert property (
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        inching_in && stop_hold_in |=> !held_run)
        else $error("self-holding kept while inching");
endmodule

// file: hw/drc_sync.sv
// two-stage synchroniser for the input terminals
`timescale 1ns/1ns
module drc_sync
    import drc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [4:0]  term_in,
    drc_core_if.syncer       bus
);
    logic [4:0] stage1;
    logic [4:0] stage2;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stage1 <= 5'h00;
            stage2 <= 5'h00;
        end else begin
            stage1 <= term_in;
            stage2 <= stage1;
        end
    end

    assign bus.term = stage2;

    sync_delay_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ##2 (stage2 == $past(term_in, 2)))
        else $error("terminal synchroniser latency wrong");
endmodule

// file: verif/drc_contacts.sv
// external contact model that opens and closes the input terminals
`timescale 1ns/1ns
module drc_contacts #(
    parameter int LAG = 3
)(
    input  wire logic       clk_in,
    input  wire logic [4:0] close_in,
    input  wire logic       slow_in,
    output logic      [4:0] term_out
);
    logic [4:0] lag_q [LAG];

    initial begin
        term_out = 5'h00;
        for (int i = 0; i < LAG; i++) begin
            lag_q[i] = 5'h00;
        end
    end

    // a slow contact settles several cycles after it is operated
    always @(posedge clk_in) begin
        lag_q[0] <= close_in;
        for (int i = 1; i < LAG; i++) begin
            lag_q[i] <= lag_q[i-1];
        end
        term_out <= slow_in ? lag_q[LAG-1] : close_in;
    end
endmodule

// file: verif/drc_run_cmd_tb.sv
// self-checking testbench for the run command decoder
`timescale 1ns/1ns
module drc_run_cmd_tb
    import drc_pkg::*;
;
    localparam int SEC   = 20;
    localparam int LIMIT = 6000;
    localparam logic [3:0] OUTS [4] = '{4'h0, 4'h9, 4'h5, 4'h2};
    logic        clk;
    logic        rst;
    logic [4:0]  contact;
    logic        slow;
    logic [4:0]  term;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        gate;
    logic        run;
    logic        decel;
    logic        coast;
    logic        rev;
    logic        second;
    int          err_count;
    int          comparisons;
    int          cycles;
    integer      seed;
    int          seq [4]  = '{1, 3, 2, 0};
    int          meth [3] = '{0, 2, 1001};
    int          secs [3] = '{0, 2, 1};

    drc_contacts i_contacts (.clk_in(clk), .close_in(contact),
        .slow_in(slow), .term_out(term));

    drc_run_cmd #(.SEC_CYC(SEC)) i_dut (
        .REF_CLK_IN(clk), .RESET_IN(rst), .TERM_IN(term), .ADDR_IN(addr),
        .WR_DATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RD_DATA_OUT(rdata),
        .GATE_ENABLE_OUT(gate), .RUN_OUT(run), .DECEL_OUT(decel),
        .COAST_OUT(coast), .REVERSE_OUT(rev), .SECOND_SET_OUT(second));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic conclude;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            $display("ERROR timeout expected finish seen %0d cycles", cycles);
            conclude;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // model: operation enable for each shutoff logic setting
    function automatic int m_enable(input int set, input int ext,
                                    input int comm);
        if (set == 0) return (ext == 0 && comm == 0);
        if (set == 2) return (ext != 0 && comm != 0);
        if (set == 4) return (ext != 0 && comm == 0);
        return 0;
    endfunction

    // model: run request and direction from the two start inputs
    function automatic int m_start(input int m, input int f, input int r,
                                   output int dir);
        dir = r;
        if ((m >= 1000 && m <= 1100) || m == 8888) return f;
        return f ^ r;
    endfunction

    task automatic chk_state(input int st, input int dir);
        chk("run decel coast gate", {28'h0, OUTS[st]},
            {28'h0, run, decel, coast, gate});
        if (st == 1) chk("reverse", 32'(dir), {31'h0, rev});
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk("read data", exp, rdata);
        @(posedge clk);
        #1;
        chk("read idle", 32'h0, rdata);
    endtask

    task automatic put(input logic [4:0] v);
        @(posedge clk);
        contact <= v;
        repeat (8) @(posedge clk);
        #1;
    endtask

    initial begin
        logic [31:0] r;
        int          setv;
        int          en;
        int          run_req;
        int          dir;
        rst = 1'b1;
        contact = 5'h00;
        slow = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        err_count = 0;
        comparisons = 0;
        cycles = 0;
        seed = 32'h34C1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk_state(0, 0);
        rd_reg(ADDR_SHUTOFF, {29'h0, RST_SHUTOFF});
        rd_reg(ADDR_STOP_METHOD, {18'h0, RST_STOP_METHOD});
        rd_reg(ADDR_FUNC_LO, {1'b0, RST_FUNC_T3, 1'b0, RST_FUNC_T2,
                              1'b0, RST_FUNC_T1, 1'b0, RST_FUNC_T0});
        rd_reg(ADDR_FUNC_HI, {25'h0, RST_FUNC_T4});
        rd_reg(ADDR_COMM, 32'h0);
        wr_reg(8'h3C, 32'hFFFFFFFF);
        rd_reg(8'h3C, 32'h0);
        // two-wire, then start plus direction
        foreach (seq[i]) begin
            put(5'(seq[i]));
            run_req = m_start(9999, seq[i] & 1, seq[i] >> 1, dir);
            chk_state(run_req != 0 ? 1 : 2, dir);
        end
        wr_reg(ADDR_STOP_METHOD, 32'd8888);
        rd_reg(ADDR_STOP_METHOD, 32'd8888);
        foreach (seq[i]) begin
            put(5'(seq[i]));
            run_req = m_start(8888, seq[i] & 1, seq[i] >> 1, dir);
            chk_state(run_req != 0 ? 1 : 2, dir);
        end
        // timed coast after start release
        foreach (meth[i]) begin
            wr_reg(ADDR_STOP_METHOD, 32'(meth[i]));
            put(5'h01);
            chk_state(1, 0);
            put(5'h00);
            if (secs[i] > 0) begin
                chk_state(2, 0);
                repeat (secs[i] * SEC - 12) @(posedge clk);
                #1;
                chk_state(2, 0);
                repeat (20) @(posedge clk);
                #1;
            end
            chk_state(3, 0);
        end
        // random shutoff logic, contacts, comm command and second set
        wr_reg(ADDR_STOP_METHOD, 32'd9999);
        wr_reg(ADDR_FUNC_LO, {1'b0, FN_SHUTOFF, 1'b0, FN_SHUTOFF,
                              1'b0, FN_REVERSE, 1'b0, FN_FORWARD});
        wr_reg(ADDR_FUNC_HI, {25'h0, FN_SECOND_SET});
        rd_reg(ADDR_FUNC_HI, {25'h0, FN_SECOND_SET});
        for (int k = 0; k < 20; k++) begin
            r = $random(seed);
            setv = (r[1:0] == 2'h3) ? 1 : 2 * r[1:0];
            slow <= r[6];
            wr_reg(ADDR_SHUTOFF, 32'(setv));
            wr_reg(ADDR_COMM, {31'h0, r[4]});
            rd_reg(ADDR_SHUTOFF, 32'(setv));
            rd_reg(ADDR_COMM, {31'h0, r[4]});
            put({r[5], r[3:2], 2'b01});
            en = m_enable(setv, r[3:2], r[4]);
            chk_state(en != 0 ? 1 : 3, 0);
            chk("second set", {31'h0, r[5]}, {31'h0, second});
        end
        // self-holding three-wire operation
        slow <= 1'b0;
        wr_reg(ADDR_SHUTOFF, 32'h0);
        wr_reg(ADDR_COMM, 32'h0);
        wr_reg(ADDR_FUNC_LO, {1'b0, FN_STOP_HOLD, 1'b0, FN_SHUTOFF,
                              1'b0, FN_REVERSE, 1'b0, FN_FORWARD});
        wr_reg(ADDR_FUNC_HI, {25'h0, FN_INCHING});
        put(5'h08);
        put(5'h09);
        put(5'h08);
        chk_state(1, 0);
        put(5'h0A);
        put(5'h08);
        chk_state(1, 1);
        put(5'h0C);
        chk_state(3, 1);
        put(5'h08);
        chk_state(1, 1);
        rd_reg(ADDR_STATUS, 32'h000008E9);
        put(5'h00);
        chk_state(2, 1);
        put(5'h18);
        put(5'h19);
        put(5'h18);
        chk_state(2, 0);
        conclude;
    end
endmodule
